// ---- hw/bcs_pkg.sv ----
// shared constants, register map and types of the bit count and shift-add unit
package bcs_pkg;
    // register byte offsets
    localparam logic [7:0] CMD_OFS = 8'h00;   // command word, a write executes it
    localparam logic [7:0] STAT_OFS = 8'h04;  // arith_status_word flags
    localparam logic [7:0] ACCL_OFS = 8'h08;  // first_accumulator bits 31..0
    localparam logic [7:0] ACCH_OFS = 8'h0C;  // first_accumulator bits 39..32
    localparam logic [7:0] INFO_OFS = 8'h10;  // unit state, read only
    localparam logic [2:0] DATA_PAGE = 3'h1;  // data registers at 0x20..0x3C
    localparam logic [2:0] PTR_PAGE = 3'h2;   // pointer registers at 0x40..0x54
    localparam int NUM_DATA = 8;              // data register count
    localparam int NUM_PTR = 6;               // pointer register count
    localparam logic [2:0] PTR_LAST = 3'h5;   // highest pointer index
    localparam int ACC_W = 40;                // accumulator width
    // arith_status_word field positions
    localparam int FLG_ZERO = 0;              // result_zero_flag
    localparam int FLG_NEG = 1;               // result_negative_flag
    localparam int FLG_OVF = 2;               // overflow flag
    localparam int FLG_STICKY = 3;            // sticky_overflow_flag
    localparam int FLG_W = 4;                 // implemented flag bits
    // info register field positions
    localparam int INFO_REFUSED = 0;          // last command refused
    // reset values
    localparam logic [3:0] FLAGS_RST = 4'h0;
    localparam logic [31:0] WORD_RST = 32'h0000_0000;
    localparam logic [39:0] ACC_RST = 40'h00_0000_0000;
    // add-shift distances
    localparam logic [1:0] SH_ONE = 2'h1;
    localparam logic [1:0] SH_TWO = 2'h2;
    // bus answers
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // operations, numbered in this order in the op field
    typedef enum logic [3:0] {
        OP_ILV_R,    // interleave, shift right
        OP_ILV_L,    // interleave, shift left
        OP_POP,      // population count into low half
        OP_ADDSH_D,  // data (dst+src)<<n
        OP_ADDSH_P,  // pointer (dst+src)<<n
        OP_SHADD_P,  // pointer adder+(src<<n)
        OP_ASR_W,    // word arithmetic right shift
        OP_ASR_H,    // low half arithmetic right shift
        OP_ASR_A,    // accumulator arithmetic right shift
        OP_LAST      // first code that is not an operation
    } bcs_op_type;

    // command word layout
    typedef struct packed {
        logic [10:0] rsvd;  // ignored
        logic [4:0] amt;    // five_bit_shift_amount, low four bits for halves
        logic by2;          // add-shift by two instead of one
        logic [2:0] srcb;   // second source / adder pointer
        logic pad2;
        logic [2:0] srca;   // first source / shifted source
        logic pad1;
        logic [2:0] dst;    // destination
        logic [3:0] op;     // bcs_op_type code
    } bcs_cmd_type;

    // axi4-lite master to slave
    typedef struct packed {
        logic [31:0] awaddr;
        logic awvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic wvalid;
        logic bready;
        logic [31:0] araddr;
        logic arvalid;
        logic rready;
    } bcs_axi_req_type;

    // axi4-lite slave to master
    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } bcs_axi_rsp_type;
endpackage

// ---- hw/bcs_popcount.sv ----
// population count of a word, as a chain of partial sums
module bcs_popcount #(
    parameter int W = 32  // word width
) (
    input wire logic [W-1:0] word,         // word to count
    output logic [$clog2(W+1)-1:0] count   // number of set bits, 0..W
);
    localparam int CW = $clog2(W + 1);

    // partial[i] holds the count of bits below i
    logic [CW-1:0] partial [W+1];

    assign partial[0] = '0;

    // one adder stage per bit; synthesis balances the chain into a tree
    for (genvar i = 0; i < W; i++)
    begin : g_bit
        assign partial[i+1] = partial[i] + CW'(word[i]);
    end

    assign count = partial[W];
endmodule

// ---- hw/bcs_unit.sv ----
// bit interleave, population count and shift-add unit behind an axi4-lite slave
// Contract
// RQ1: right interleave inserts first then second lsb
// RQ2: left interleave inserts second then first msb
// RQ3: left interleave moves accumulator two places
// RQ4: interleave, count, shift-add keep flags
// RQ5: set-bit count written to destination low half
// RQ6: count result lies within zero to thirty-two
// RQ7: same register allowed; otherwise source kept
// RQ8: add-then-shift adds, shifts left one/two
// RQ9: add-then-shift never saturates, drops high bits
// RQ10: add-then-shift changes destination, keeps source
// RQ11: data add-then-shift sets zero, negative, overflow, sticky
// RQ12: pointer add-then-shift keeps every flag
// RQ13: shift-then-add shifts source, adds adder pointer
// RQ14: arithmetic right shift refills with sign
// RQ15: shift amount four bits halves, five words
module bcs_unit (
    input wire logic aclk,                          // core clock
    input wire logic aresetn,                       // synchronous reset, low active
    input wire bcs_pkg::bcs_axi_req_type s_axi_req, // bus requests
    output bcs_pkg::bcs_axi_rsp_type s_axi_rsp      // bus answers
);
    // architectural state
    logic [31:0] data_r [bcs_pkg::NUM_DATA];  // data registers
    logic [31:0] data_nxt [bcs_pkg::NUM_DATA];
    logic [31:0] ptr_r [bcs_pkg::NUM_PTR];    // pointer registers
    logic [31:0] ptr_nxt [bcs_pkg::NUM_PTR];
    logic [39:0] acc_r;                       // first_accumulator
    logic [39:0] acc_nxt;
    logic [3:0] flags_r;                      // arith_status_word
    logic [3:0] flags_nxt;
    logic [31:0] cmd_r;                       // last command written
    logic refused_r;                          // last command refused

    // bus state
    logic awready_r;
    logic wready_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic arready_r;
    logic rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0] rresp_r;
    logic aw_got_r;        // write address held
    logic w_got_r;         // write data held
    logic [31:0] awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;

    // byte-lane merge of a write into an old value
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++)
        begin
            if (strb[b])
            begin
                res[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
        return res;
    endfunction

    // handshakes
    wire aw_hs = s_axi_req.awvalid & awready_r;
    wire w_hs = s_axi_req.wvalid & wready_r;
    wire ar_hs = s_axi_req.arvalid & arready_r;
    wire wr_do = aw_got_r & w_got_r & ~bvalid_r;  // write performed this cycle
    wire aw_got_nxt = wr_do ? 1'b0 : (aw_got_r | aw_hs);
    wire w_got_nxt = wr_do ? 1'b0 : (w_got_r | w_hs);
    wire bvalid_nxt = wr_do | (bvalid_r & ~s_axi_req.bready);
    wire rvalid_nxt = ar_hs | (rvalid_r & ~s_axi_req.rready);

    // write decode; upper address bits or a misaligned address miss
    wire wa_low = (awaddr_r[31:8] == 24'h0) && (awaddr_r[1:0] == 2'h0);
    wire [7:0] wa = awaddr_r[7:0];
    wire [2:0] wa_idx = wa[4:2];
    wire sel_cmd = wa_low && (wa == bcs_pkg::CMD_OFS);
    wire sel_stat = wa_low && (wa == bcs_pkg::STAT_OFS);
    wire sel_accl = wa_low && (wa == bcs_pkg::ACCL_OFS);
    wire sel_acch = wa_low && (wa == bcs_pkg::ACCH_OFS);
    wire sel_info = wa_low && (wa == bcs_pkg::INFO_OFS);
    wire sel_data = wa_low && (wa[7:5] == bcs_pkg::DATA_PAGE);
    wire sel_ptr = wa_low && (wa[7:5] == bcs_pkg::PTR_PAGE) && (wa_idx <= bcs_pkg::PTR_LAST);
    wire wr_hit = sel_cmd | sel_stat | sel_accl | sel_acch | sel_info | sel_data | sel_ptr;

    // read decode
    wire ra_low = (s_axi_req.araddr[31:8] == 24'h0) && (s_axi_req.araddr[1:0] == 2'h0);
    wire [7:0] ra = s_axi_req.araddr[7:0];
    wire [2:0] ra_idx = ra[4:2];
    wire rd_data = ra_low && (ra[7:5] == bcs_pkg::DATA_PAGE);
    wire rd_ptr = ra_low && (ra[7:5] == bcs_pkg::PTR_PAGE) && (ra_idx <= bcs_pkg::PTR_LAST);
    wire [2:0] ra_pidx = rd_ptr ? ra_idx : 3'h0;
    wire [31:0] info_word = {31'h0, refused_r};
    wire rd_hit = rd_data | rd_ptr | (ra_low && ((ra == bcs_pkg::CMD_OFS) ||
                  (ra == bcs_pkg::STAT_OFS) || (ra == bcs_pkg::ACCL_OFS) ||
                  (ra == bcs_pkg::ACCH_OFS) || (ra == bcs_pkg::INFO_OFS)));
    wire [31:0] rd_word =
        rd_data ? data_r[ra_idx] :
        rd_ptr ? ptr_r[ra_pidx] :
        !ra_low ? bcs_pkg::WORD_RST :
        (ra == bcs_pkg::CMD_OFS) ? cmd_r :
        (ra == bcs_pkg::STAT_OFS) ? {28'h0, flags_r} :
        (ra == bcs_pkg::ACCL_OFS) ? acc_r[31:0] :
        (ra == bcs_pkg::ACCH_OFS) ? {24'h0, acc_r[39:32]} :
        (ra == bcs_pkg::INFO_OFS) ? info_word : bcs_pkg::WORD_RST;

    // command decode; a write to the command word executes it at once
    wire [31:0] cmd_word = merge(cmd_r, wdata_r, wstrb_r);
    // status and high accumulator writes, merged at full width then cut to size
    wire [31:0] stat_wr = merge({28'h0, flags_r}, wdata_r, wstrb_r);
    wire [31:0] acch_wr = merge({24'h0, acc_r[39:32]}, wdata_r, wstrb_r);
    wire bcs_pkg::bcs_cmd_type cmd = bcs_pkg::bcs_cmd_type'(cmd_word);
    wire op_ok = cmd.op < 4'(bcs_pkg::OP_LAST);
    wire bcs_pkg::bcs_op_type op = op_ok ? bcs_pkg::bcs_op_type'(cmd.op) : bcs_pkg::OP_ILV_R;
    wire is_ptr_op = (op == bcs_pkg::OP_ADDSH_P) || (op == bcs_pkg::OP_SHADD_P);
    wire is_ilv = (op == bcs_pkg::OP_ILV_R) || (op == bcs_pkg::OP_ILV_L);
    wire ptr_idx_ok = (cmd.dst <= bcs_pkg::PTR_LAST) && (cmd.srca <= bcs_pkg::PTR_LAST) &&
                      (cmd.srcb <= bcs_pkg::PTR_LAST);
    // the two interleave streams must be different registers
    wire cmd_ok = op_ok && (!is_ptr_op || ptr_idx_ok) && (!is_ilv || (cmd.srca != cmd.srcb));
    wire exec_go = wr_do && sel_cmd && cmd_ok;

    // operands
    wire [31:0] opa = data_r[cmd.srca];   // first source / add source
    wire [31:0] opb = data_r[cmd.srcb];   // second source
    wire [31:0] dval = data_r[cmd.dst];   // destination as operand
    wire [2:0] pd_i = ptr_idx_ok ? cmd.dst : 3'h0;
    wire [2:0] pa_i = ptr_idx_ok ? cmd.srca : 3'h0;
    wire [2:0] pb_i = ptr_idx_ok ? cmd.srcb : 3'h0;
    wire [31:0] pd = ptr_r[pd_i];
    wire [31:0] pa = ptr_r[pa_i];
    wire [31:0] pb = ptr_r[pb_i];
    wire [1:0] sh = cmd.by2 ? bcs_pkg::SH_TWO : bcs_pkg::SH_ONE;

    // datapath results
    wire [5:0] ones;
    wire [32:0] sum33 = {dval[31], dval} + {opa[31], opa};
    wire [34:0] sh35 = {sum33[32], sum33[32], sum33} << sh;
    wire [31:0] addsh_res = sh35[31:0];  // see RQ8 see RQ9
    // overflow when the kept word no longer equals the exact signed value
    wire addsh_ovf = (sh35[34:31] != 4'h0) && (sh35[34:31] != 4'hF);
    wire [31:0] paddsh_res = (pd + pa) << sh;  // see RQ8
    wire [31:0] shadd_res = pb + (pa << sh);   // see RQ13
    wire [31:0] asrw_res = 32'($signed(opa) >>> cmd.amt);            // see RQ14 see RQ15
    wire [15:0] asrh_res = 16'($signed(opa[15:0]) >>> cmd.amt[3:0]); // see RQ14 see RQ15
    wire [39:0] asra_res = 40'($signed(acc_r) >>> cmd.amt);          // see RQ14 see RQ15

    // population count, zero to thirty-two, fits the low half
    bcs_popcount #(
        .W(32)
    ) u_pop (
        .word(opa),
        .count(ones)
    );

    // next-state of the programmer-visible registers
    always_comb
    begin
        data_nxt = data_r;
        ptr_nxt = ptr_r;
        acc_nxt = acc_r;
        flags_nxt = flags_r;
        // plain register writes
        if (wr_do && sel_data)
        begin
            data_nxt[wa_idx] = merge(data_r[wa_idx], wdata_r, wstrb_r);
        end
        if (wr_do && sel_ptr)
        begin
            ptr_nxt[wa_idx] = merge(ptr_r[wa_idx], wdata_r, wstrb_r);
        end
        if (wr_do && sel_stat)
        begin
            flags_nxt = stat_wr[3:0];
        end
        if (wr_do && sel_accl)
        begin
            acc_nxt[31:0] = merge(acc_r[31:0], wdata_r, wstrb_r);
        end
        if (wr_do && sel_acch)
        begin
            acc_nxt[39:32] = acch_wr[7:0];
        end
        // operations; the flag defaults above keep flags for the quiet ones
        if (exec_go)
        begin
            case (op)
                bcs_pkg::OP_ILV_R:
                begin
                    acc_nxt = {opb[0], opa[0], acc_r[39:2]};  // see RQ1 see RQ4
                    data_nxt[cmd.srca] = opa >> 1;
                    data_nxt[cmd.srcb] = opb >> 1;
                end
                bcs_pkg::OP_ILV_L:
                begin
                    acc_nxt = {acc_r[37:0], opb[31], opa[31]};  // see RQ2 see RQ3
                    data_nxt[cmd.srca] = opa << 1;
                    data_nxt[cmd.srcb] = opb << 1;
                end
                bcs_pkg::OP_POP:
                begin
                    data_nxt[cmd.dst] = {dval[31:16], 10'h0, ones};  // see RQ5 see RQ6 see RQ7
                end
                bcs_pkg::OP_ADDSH_D:
                begin
                    data_nxt[cmd.dst] = addsh_res;  // see RQ10
                    flags_nxt[bcs_pkg::FLG_ZERO] = (addsh_res == 32'h0);  // see RQ11
                    flags_nxt[bcs_pkg::FLG_NEG] = addsh_res[31];
                    flags_nxt[bcs_pkg::FLG_OVF] = addsh_ovf;
                    flags_nxt[bcs_pkg::FLG_STICKY] = flags_r[bcs_pkg::FLG_STICKY] | addsh_ovf;
                end
                bcs_pkg::OP_ADDSH_P:
                begin
                    ptr_nxt[pd_i] = paddsh_res;  // see RQ12
                end
                bcs_pkg::OP_SHADD_P:
                begin
                    ptr_nxt[pd_i] = shadd_res;  // see RQ4
                end
                bcs_pkg::OP_ASR_W:
                begin
                    data_nxt[cmd.dst] = asrw_res;
                    flags_nxt[bcs_pkg::FLG_ZERO] = (asrw_res == 32'h0);
                    flags_nxt[bcs_pkg::FLG_NEG] = asrw_res[31];
                    flags_nxt[bcs_pkg::FLG_OVF] = 1'b0;  // a right shift cannot overflow
                end
                bcs_pkg::OP_ASR_H:
                begin
                    data_nxt[cmd.dst] = {dval[31:16], asrh_res};
                    flags_nxt[bcs_pkg::FLG_ZERO] = (asrh_res == 16'h0);
                    flags_nxt[bcs_pkg::FLG_NEG] = asrh_res[15];
                    flags_nxt[bcs_pkg::FLG_OVF] = 1'b0;
                end
                bcs_pkg::OP_ASR_A:
                begin
                    acc_nxt = asra_res;
                    flags_nxt[bcs_pkg::FLG_ZERO] = (asra_res == 40'h0);
                    flags_nxt[bcs_pkg::FLG_NEG] = asra_res[39];
                end
                default:
                begin
                    acc_nxt = acc_r;
                end
            endcase
        end
    end

    // register flops, one per data and pointer register
    for (genvar i = 0; i < bcs_pkg::NUM_DATA; i++)
    begin : g_data
        always_ff @(posedge aclk)
        begin
            data_r[i] <= !aresetn ? bcs_pkg::WORD_RST : data_nxt[i];
        end
    end
    for (genvar i = 0; i < bcs_pkg::NUM_PTR; i++)
    begin : g_ptr
        always_ff @(posedge aclk)
        begin
            ptr_r[i] <= !aresetn ? bcs_pkg::WORD_RST : ptr_nxt[i];
        end
    end

    // accumulator, flags, command and refusal state
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            acc_r <= bcs_pkg::ACC_RST;
            flags_r <= bcs_pkg::FLAGS_RST;
            cmd_r <= bcs_pkg::WORD_RST;
            refused_r <= 1'b0;
        end
        else
        begin
            acc_r <= acc_nxt;
            flags_r <= flags_nxt;
            if (wr_do && sel_cmd)
            begin
                cmd_r <= cmd_word;
                refused_r <= !cmd_ok;
            end
        end
    end

    // write channel: address and data taken in any order, answer after both
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            awready_r <= 1'b0;
            wready_r <= 1'b0;
            bvalid_r <= 1'b0;
            bresp_r <= bcs_pkg::RESP_OKAY;
            awaddr_r <= bcs_pkg::WORD_RST;
            wdata_r <= bcs_pkg::WORD_RST;
            wstrb_r <= 4'h0;
        end
        else
        begin
            aw_got_r <= aw_got_nxt;
            w_got_r <= w_got_nxt;
            awready_r <= ~(aw_got_nxt | bvalid_nxt);
            wready_r <= ~(w_got_nxt | bvalid_nxt);
            bvalid_r <= bvalid_nxt;
            if (aw_hs)
            begin
                awaddr_r <= s_axi_req.awaddr;
            end
            if (w_hs)
            begin
                wdata_r <= s_axi_req.wdata;
                wstrb_r <= s_axi_req.wstrb;
            end
            if (wr_do)
            begin
                bresp_r <= (wr_hit && !sel_info) ? bcs_pkg::RESP_OKAY : bcs_pkg::RESP_SLVERR;
            end
        end
    end

    // read channel: data registered at the address handshake
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            arready_r <= 1'b0;
            rvalid_r <= 1'b0;
            rdata_r <= bcs_pkg::WORD_RST;
            rresp_r <= bcs_pkg::RESP_OKAY;
        end
        else
        begin
            arready_r <= ~rvalid_nxt;
            rvalid_r <= rvalid_nxt;
            if (ar_hs)
            begin
                rdata_r <= rd_word;
                rresp_r <= rd_hit ? bcs_pkg::RESP_OKAY : bcs_pkg::RESP_SLVERR;
            end
        end
    end

    assign s_axi_rsp = '{awready: awready_r, wready: wready_r, bvalid: bvalid_r,
                         bresp: bresp_r, arready: arready_r, rvalid: rvalid_r,
                         rdata: rdata_r, rresp: rresp_r};

    // checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_go(bcs_pkg::bcs_op_type o);
        exec_go && (op == o);
    endsequence

    AST_ILV_RIGHT: assert property (s_go(bcs_pkg::OP_ILV_R) |=> // see RQ1
        (acc_r == {$past(opb[0]), $past(opa[0]), $past(acc_r[39:2])}))
        else $error("right interleave accumulator wrong");
    AST_ILV_LEFT: assert property (s_go(bcs_pkg::OP_ILV_L) |=> // see RQ2
        (acc_r == {$past(acc_r[37:0]), $past(opb[31]), $past(opa[31])}))
        else $error("left interleave accumulator wrong");
    AST_ILV_SRC: assert property (s_go(bcs_pkg::OP_ILV_L) |=> // see RQ3
        (data_r[$past(cmd.srca)] == ($past(opa) << 1)) && (data_r[$past(cmd.srcb)] ==
        ($past(opb) << 1)))
        else $error("left interleave sources not shifted");
    AST_QUIET_FLAGS: assert property ((exec_go && (is_ilv || op == bcs_pkg::OP_POP || // see RQ4
        op == bcs_pkg::OP_SHADD_P)) |=> $stable(flags_r))
        else $error("flags changed by quiet operation");
    AST_POP_COUNT: assert property (s_go(bcs_pkg::OP_POP) |=> // see RQ5
        (data_r[$past(cmd.dst)] == {$past(dval[31:16]), 16'($countones($past(opa)))}))
        else $error("population count wrong");
    AST_POP_RANGE: assert property (s_go(bcs_pkg::OP_POP) |=> // see RQ6
        (data_r[$past(cmd.dst)][15:0] <= 16'h0020))
        else $error("population count out of range");
    AST_POP_SRC: assert property ((s_go(bcs_pkg::OP_POP) ##0 (cmd.dst != cmd.srca)) |=> // see RQ7
        (data_r[$past(cmd.srca)] == $past(opa)))
        else $error("population count source altered");
    AST_ADDSH_DATA: assert property (s_go(bcs_pkg::OP_ADDSH_D) |=> // see RQ8
        (data_r[$past(cmd.dst)] == 32'(($past(dval) + $past(opa)) << $past(sh))))
        else $error("add-shift result wrong");
    AST_ADDSH_FLAGS: assert property (s_go(bcs_pkg::OP_ADDSH_D) |=> // see RQ11
        ((flags_r[bcs_pkg::FLG_ZERO] == (data_r[$past(cmd.dst)] == 32'h0)) &&
        (flags_r[bcs_pkg::FLG_NEG] == data_r[$past(cmd.dst)][31]) &&
        (flags_r[bcs_pkg::FLG_STICKY] == ($past(flags_r[bcs_pkg::FLG_STICKY]) |
        flags_r[bcs_pkg::FLG_OVF]))))
        else $error("add-shift flags wrong");
    AST_PADDSH: assert property (s_go(bcs_pkg::OP_ADDSH_P) |=> // see RQ12
        ($stable(flags_r) && (ptr_r[$past(pd_i)] == 32'(($past(pd) + $past(pa)) << $past(sh)))))
        else $error("pointer add-shift wrong");
    AST_SHADD: assert property (s_go(bcs_pkg::OP_SHADD_P) |=> // see RQ13
        (ptr_r[$past(pd_i)] == 32'($past(pb) + ($past(pa) << $past(sh)))))
        else $error("shift-add wrong");
    AST_ASR_HALF: assert property (s_go(bcs_pkg::OP_ASR_H) |=> // see RQ15
        (data_r[$past(cmd.dst)][15:0] == 16'($signed($past(opa[15:0])) >>> $past(cmd.amt[3:0]))))
        else $error("half arithmetic shift wrong");
endmodule

// ---- testbench/bcs_bus_master.sv ----
// axi4-lite master model standing in for the core decoder and register file
module bcs_bus_master (
    input wire logic aclk, // core clock
    input wire bcs_pkg::bcs_axi_rsp_type rsp, // slave answers
    output bcs_pkg::bcs_axi_req_type req // master requests
);
    timeunit 1ns;
    timeprecision 1ps;
    initial req = '0; // idle until the first request
    // one write, address and data offered together, each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic aw = 1'b0;
        logic w = 1'b0;
        @(posedge aclk);
        req.awaddr <= {24'h0, a};
        req.wdata <= d;
        req.wstrb <= 4'hF;
        {req.awvalid, req.wvalid, req.bready} <= 3'h7;
        while (!(aw && w))
        begin
            @(posedge aclk);
            aw |= rsp.awready;
            w |= rsp.wready;
            req.awvalid <= !aw;
            req.wvalid <= !w;
        end
        // released payload shows its inverse so a stale value cannot pass
        req.wdata <= ~d;
        req.awaddr <= ~{24'h0, a};
        do @(posedge aclk); while (rsp.bvalid !== 1'b1);
        r = rsp.bresp;
        req.bready <= 1'b0;
    endtask
    // one read, rready held from the start until the answer is sampled
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        req.araddr <= {24'h0, a};
        {req.arvalid, req.rready} <= 2'h3;
        do @(posedge aclk); while (rsp.arready !== 1'b1);
        req.arvalid <= 1'b0;
        req.araddr <= ~{24'h0, a};
        do @(posedge aclk); while (rsp.rvalid !== 1'b1);
        d = rsp.rdata;
        r = rsp.rresp;
        req.rready <= 1'b0;
    endtask
endmodule

// ---- testbench/testbench.sv ----
// self-checking bench of the bit count and shift-add unit
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk = 1'b0; // core clock
    logic aresetn = 1'b0; // reset, low active
    bcs_pkg::bcs_axi_req_type req; // bus requests
    bcs_pkg::bcs_axi_rsp_type rsp; // bus answers
    int n_fail = 0; // mismatches
    int checks = 0; // comparisons
    always #5 aclk = ~aclk;
    bcs_unit bcs_unit_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_req(req), .s_axi_rsp(rsp));
    bcs_bus_master bcs_bus_master_inst (.aclk(aclk), .rsp(rsp), .req(req));
    // compare one value and count it
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        checks++;
        if (s !== e)
        begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask
    // bus write, answer code judged
    task automatic wv(input logic [7:0] a, input logic [31:0] d);
        logic [1:0] r;
        bcs_bus_master_inst.wr(a, d, r);
        chk("bresp", {30'h0, r}, {30'h0, bcs_pkg::RESP_OKAY});
    endtask
    // bus read, data and answer code judged
    task automatic rv(input logic [7:0] a, input logic [31:0] e,
                      input logic [1:0] er = bcs_pkg::RESP_OKAY);
        logic [31:0] d;
        logic [1:0] r;
        bcs_bus_master_inst.rd(a, d, r);
        chk($sformatf("rdata at %h", a), d, e);
        chk("rresp", {30'h0, r}, {30'h0, er});
    endtask
    // issue one command word
    task automatic ex(input int op, dst, sa, sb, b2, input int am = 0);
        wv(bcs_pkg::CMD_OFS, {11'h0, am[4:0], b2[0], sb[2:0], 1'b0, sa[2:0], 1'b0, dst[2:0],
                              op[3:0]});
    endtask
    // byte address of register i in a page
    function automatic logic [7:0] rg(input logic [7:0] base, input int i);
        return base + 8'(4 * i);
    endfunction
    task automatic t_pop;
        wv(bcs_pkg::STAT_OFS, 32'hF);
        wv(rg(8'h20, 1), 32'hFFFFFFFF);
        wv(rg(8'h20, 2), 32'hFFFF1234);
        ex(2, 2, 1, 0, 0);
        rv(rg(8'h20, 2), 32'hFFFF0020);
        rv(rg(8'h20, 1), 32'hFFFFFFFF);
        ex(2, 1, 1, 0, 0);
        rv(rg(8'h20, 1), 32'hFFFF0020);
        rv(bcs_pkg::STAT_OFS, 32'hF);
        $display("test pop done");
    endtask
    task automatic t_add;
        wv(bcs_pkg::STAT_OFS, 32'h0);
        wv(rg(8'h20, 4), 32'h40000000);
        wv(rg(8'h20, 5), 32'h1);
        ex(3, 4, 5, 0, 0);
        rv(rg(8'h20, 4), 32'h80000002);
        rv(bcs_pkg::STAT_OFS, 32'hE);
        ex(3, 4, 5, 0, 1);
        rv(rg(8'h20, 4), 32'hC);
        rv(rg(8'h20, 5), 32'h1);
        rv(bcs_pkg::STAT_OFS, 32'hC);
        $display("test add-shift done");
    endtask
    task automatic t_ptr;
        wv(rg(8'h40, 0), 32'h80000001);
        wv(rg(8'h40, 1), 32'h1);
        ex(4, 0, 1, 0, 1);
        rv(rg(8'h40, 0), 32'h8);
        ex(5, 2, 1, 0, 0);
        rv(rg(8'h40, 2), 32'hA);
        rv(bcs_pkg::STAT_OFS, 32'hC);
        rv(8'h18, 32'h0, bcs_pkg::RESP_SLVERR);
        $display("test pointer done");
    endtask
    task automatic t_ilv;
        wv(bcs_pkg::ACCL_OFS, 32'h7);
        wv(rg(8'h20, 2), 32'hA5A5C3AA);
        wv(rg(8'h20, 3), 32'hC3AAA5A5);
        ex(0, 0, 2, 3, 0);
        rv(bcs_pkg::ACCH_OFS, 32'h80);
        rv(rg(8'h20, 3), 32'h61D552D2);
        wv(rg(8'h20, 3), 32'hA5A5C3AA);
        ex(1, 0, 3, 2, 0);
        rv(bcs_pkg::ACCL_OFS, 32'h5);
        rv(bcs_pkg::ACCH_OFS, 32'h0);
        rv(rg(8'h20, 2), 32'hA5A5C3AA);
        rv(bcs_pkg::STAT_OFS, 32'hC);
        $display("test interleave done");
    endtask
    task automatic t_asr;
        wv(rg(8'h20, 6), 32'h80000000);
        ex(6, 7, 6, 0, 0, 31);
        rv(rg(8'h20, 7), 32'hFFFFFFFF);
        rv(bcs_pkg::STAT_OFS, 32'hA);
        wv(rg(8'h20, 5), 32'h12348000);
        ex(7, 6, 5, 0, 0, 20);
        rv(rg(8'h20, 6), 32'h8000F800);
        ex(6, 7, 5, 0, 0, 31);
        rv(rg(8'h20, 7), 32'h0);
        rv(bcs_pkg::STAT_OFS, 32'h9);
        wv(bcs_pkg::ACCH_OFS, 32'h80);
        ex(8, 0, 0, 0, 0, 4);
        rv(bcs_pkg::ACCH_OFS, 32'hF8);
        rv(bcs_pkg::ACCL_OFS, 32'h0);
        ex(0, 0, 4, 4, 0);
        rv(bcs_pkg::INFO_OFS, 32'h1);
        rv(bcs_pkg::ACCH_OFS, 32'hF8);
        $display("test arithmetic shift done");
    endtask
    // print the counts and the verdict, then stop
    task automatic complete_run;
        $display("checks %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // hang guard: the whole run needs well under this many cycles
    initial
    begin
        repeat (20000) @(posedge aclk);
        n_fail++;
        complete_run();
    end
    // reset for three cycles, then the scenarios
    initial
    begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        t_pop();
        t_add();
        t_ptr();
        t_ilv();
        t_asr();
        complete_run();
    end
endmodule
